/* core/instr_exec_state_timing.sv */
// Execution state sequencer: computes and times one instruction
`timescale 1ns/10ps

// Overview of operation
// - Each state lasts one system clock period.
// - I, J, K added for slow regions.
// - Narrow bus, on-chip fetch: base plus adjustment.
// - Narrow, module/off-chip operand: I byte, 2I word.
// - Narrow off-chip fetch adds twice (J+K).
// - On-chip fetch parity changes count by 1-2.
// - External wait states lengthen the instruction.
// - Wide: 16-bit 3-state word operand adds I/2.
// - Wide: 8-bit 3-state word operand adds 2I.
// - Wide: 16-bit 3-state fetch adds (J+K)/2.
// - That halved fetch term rounds down.
// - Wide: 8-bit 2-state fetch adds J+K, no adjustment.
// - Wide: 8-bit 3-state fetch adds 2(J+K).
// - Wait and idle states in 3-state space add.
// - Wide: 16-bit fetch parity changes count by 1-2.

module instr_exec_state_timing #(
  parameter int BASE_W = exec_timing_pkg::BASE_W,
  parameter int PARAM_W = exec_timing_pkg::PARAM_W,
  parameter int TOTAL_W = exec_timing_pkg::TOTAL_W
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic start,
  input wire exec_timing_pkg::bus_variant_e busVariant,
  input wire exec_timing_pkg::region_e fetchRegion,
  input wire exec_timing_pkg::region_e operandRegion,
  input wire logic wordAccess,
  input wire logic oddStart,
  input wire logic [BASE_W-1:0] baseCount,
  input wire logic [BASE_W-1:0] modeAdjEven,
  input wire logic [BASE_W-1:0] modeAdjOdd,
  input wire logic [PARAM_W-1:0] operandParam,
  input wire logic [PARAM_W-1:0] fetchParamJ,
  input wire logic [PARAM_W-1:0] fetchParamK,
  input wire logic waitState,
  input wire logic bus_idle_state,
  output logic busy,
  output logic done,
  output logic [TOTAL_W-1:0] calcTotal,
  output logic [TOTAL_W-1:0] finalTotal,
  output logic [TOTAL_W-1:0] extraStates
);

  typedef logic [TOTAL_W-1:0] count_t;

  typedef struct packed {
    exec_timing_pkg::seq_state_e st;
    logic stretchable;
    count_t remaining;
    count_t calc;
    count_t extra;
    count_t final_;
    logic busy;
    logic done;
  } timing_s;

  timing_s cur;
  timing_s next_cur;
  count_t computed;
  logic stall;

  state_total_calc #(
    .BASE_W(BASE_W),
    .PARAM_W(PARAM_W),
    .TOTAL_W(TOTAL_W)
  ) u_calc (
    .busVariant(busVariant),
    .fetchRegion(fetchRegion),
    .operandRegion(operandRegion),
    .wordAccess(wordAccess),
    .oddStart(oddStart),
    .baseCount(baseCount),
    .modeAdjEven(modeAdjEven),
    .modeAdjOdd(modeAdjOdd),
    .operandParam(operandParam),
    .fetchParamJ(fetchParamJ),
    .fetchParamK(fetchParamK),
    .stateTotal(computed)
  );

  // Only accesses that can be stretched by the memory side
  function automatic logic canStretch(
    input exec_timing_pkg::bus_variant_e v,
    input exec_timing_pkg::region_e f,
    input exec_timing_pkg::region_e o
  );
    if (v == exec_timing_pkg::BUS_NARROW) begin
      canStretch = (f != exec_timing_pkg::RG_FAST) ||
        (o != exec_timing_pkg::RG_FAST);
    end else begin
      canStretch = (f == exec_timing_pkg::RG_W16S3) ||
        (f == exec_timing_pkg::RG_SLOW) ||
        (o == exec_timing_pkg::RG_W16S3) ||
        (o == exec_timing_pkg::RG_SLOW);
    end
  endfunction

  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    // Narrow variant counts idle states too, harmless when unused
    stall = cur.stretchable && (waitState || bus_idle_state);
    unique case (cur.st)
      exec_timing_pkg::ST_IDLE: begin
        if (start) begin
          next_cur.st = exec_timing_pkg::ST_RUN;
          next_cur.busy = 1'b1;
          next_cur.calc = computed;
          // A zero count would wrap and take 4096 states; floor at one state
          next_cur.remaining = (computed == '0) ? count_t'(1) : computed;
          next_cur.extra = '0;
          next_cur.stretchable = canStretch(busVariant, fetchRegion,
            operandRegion);
        end
      end
      exec_timing_pkg::ST_RUN: begin
        if (stall) begin
          next_cur.extra = count_t'(cur.extra + count_t'(1));
        end else if (cur.remaining == count_t'(1)) begin
          next_cur.st = exec_timing_pkg::ST_IDLE;
          next_cur.busy = 1'b0;
          next_cur.done = 1'b1;
          next_cur.remaining = '0;
          next_cur.final_ = count_t'(cur.calc + cur.extra);
        end else begin
          // One state per clock at this rate
          next_cur.remaining = count_t'(cur.remaining -
            count_t'(exec_timing_pkg::STATE_CYCLES));
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cur <= '{st: exec_timing_pkg::ST_IDLE, stretchable: 1'b0,
        remaining: exec_timing_pkg::TOTAL_RST,
        calc: exec_timing_pkg::TOTAL_RST,
        extra: exec_timing_pkg::TOTAL_RST,
        final_: exec_timing_pkg::TOTAL_RST, busy: 1'b0, done: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign busy = cur.busy;
  assign done = cur.done;
  assign calcTotal = cur.calc;
  assign finalTotal = cur.final_;
  assign extraStates = cur.extra;

endmodule

/* common/exec_timing_pkg.sv */
// Constants and types shared by the execution state timing block
package exec_timing_pkg;

  // System clock of this build, and the length of one execution state
  localparam int CLK_PERIOD_NS = 50;
  localparam int STATE_LEN_NS = 50;
  // One state is one clock period; never less than one cycle
  localparam int STATE_CYCLES_RAW = STATE_LEN_NS / CLK_PERIOD_NS;
  localparam int STATE_CYCLES = (STATE_CYCLES_RAW < 1) ? 1 :
    STATE_CYCLES_RAW;

  // Default widths
  localparam int BASE_W = 8;
  localparam int PARAM_W = 8;
  localparam int TOTAL_W = 12;

  // Reset values
  localparam logic [TOTAL_W-1:0] TOTAL_RST = 12'h000;

  // External bus variant of the chip
  typedef enum logic {
    BUS_NARROW = 1'b0,
    BUS_WIDE = 1'b1
  } bus_variant_e;

  // Address region of a fetch or an operand access.
  // Narrow variant: FAST is on-chip memory, general register or no
  // operand; SLOW is a supporting module or off-chip memory.
  // Wide variant: FAST is 16-bit 2-state space or general register,
  // W16S3 16-bit 3-state, W8S2 8-bit 2-state, SLOW 8-bit 3-state or
  // on-chip register field.
  typedef enum logic [1:0] {
    RG_FAST = 2'h0,
    RG_W16S3 = 2'h1,
    RG_W8S2 = 2'h2,
    RG_SLOW = 2'h3
  } region_e;

  // Sequencer states, Gray coded
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } seq_state_e;

endpackage

/* core/state_total_calc.sv */
// Combinational count of execution states for one instruction
`timescale 1ns/10ps

module state_total_calc #(
  parameter int BASE_W = exec_timing_pkg::BASE_W,
  parameter int PARAM_W = exec_timing_pkg::PARAM_W,
  parameter int TOTAL_W = exec_timing_pkg::TOTAL_W
) (
  input wire exec_timing_pkg::bus_variant_e busVariant,
  input wire exec_timing_pkg::region_e fetchRegion,
  input wire exec_timing_pkg::region_e operandRegion,
  input wire logic wordAccess,
  input wire logic oddStart,
  input wire logic [BASE_W-1:0] baseCount,
  input wire logic [BASE_W-1:0] modeAdjEven,
  input wire logic [BASE_W-1:0] modeAdjOdd,
  input wire logic [PARAM_W-1:0] operandParam,
  input wire logic [PARAM_W-1:0] fetchParamJ,
  input wire logic [PARAM_W-1:0] fetchParamK,
  output logic [TOTAL_W-1:0] stateTotal
);

  typedef logic [TOTAL_W-1:0] total_t;

  // Widen then halve, dropping the remainder
  function automatic total_t halfDown(input total_t v);
    halfDown = v >> 1;
  endfunction

  function automatic total_t widen(input logic [PARAM_W-1:0] v);
    widen = total_t'(v);
  endfunction

  total_t valI;
  total_t sumJK;
  total_t adj;
  total_t opTerm;
  total_t fetchTerm;

  always_comb begin
    valI = widen(operandParam);
    sumJK = total_t'(widen(fetchParamJ) + widen(fetchParamK));
    // Parity of the start address picks the adjustment
    adj = oddStart ? total_t'(modeAdjOdd) : total_t'(modeAdjEven);
    opTerm = '0;
    fetchTerm = '0;
    if (busVariant == exec_timing_pkg::BUS_NARROW) begin
      // Anything not on-chip counts as module or off-chip
      if (operandRegion != exec_timing_pkg::RG_FAST) begin
        opTerm = wordAccess ? total_t'(valI << 1) : valI;
      end
      if (fetchRegion == exec_timing_pkg::RG_FAST) begin
        fetchTerm = adj;
      end else begin
        fetchTerm = total_t'(sumJK << 1);
      end
    end else begin
      unique case (operandRegion)
        exec_timing_pkg::RG_FAST: opTerm = '0;
        exec_timing_pkg::RG_W16S3: begin
          opTerm = wordAccess ? halfDown(valI) : valI;
        end
        exec_timing_pkg::RG_W8S2: begin
          opTerm = wordAccess ? valI : '0;
        end
        exec_timing_pkg::RG_SLOW: begin
          opTerm = wordAccess ? total_t'(valI << 1) : valI;
        end
      endcase
      unique case (fetchRegion)
        exec_timing_pkg::RG_FAST: fetchTerm = adj;
        exec_timing_pkg::RG_W16S3: begin
          if (wordAccess && operandRegion == exec_timing_pkg::RG_W16S3)
              begin
            // Halved together, so one rounding only
            opTerm = '0;
            fetchTerm = total_t'(adj + halfDown(total_t'(valI + sumJK)));
          end else begin
            fetchTerm = total_t'(adj + halfDown(sumJK));
          end
        end
        exec_timing_pkg::RG_W8S2: fetchTerm = sumJK;
        exec_timing_pkg::RG_SLOW: begin
          fetchTerm = total_t'(sumJK << 1);
        end
      endcase
    end
    stateTotal = total_t'(total_t'(baseCount) + opTerm + fetchTerm);
  end

endmodule

/* tb/exec_timing_sva.sv */
// Checker on the ports of the execution state sequencer
`timescale 1ns/10ps

module exec_timing_sva #(
  parameter int TOTAL_W = 12
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic start,
  input wire logic waitState,
  input wire logic bus_idle_state,
  input wire logic busy,
  input wire logic done,
  input wire logic [TOTAL_W-1:0] calcTotal,
  input wire logic [TOTAL_W-1:0] finalTotal,
  input wire logic [TOTAL_W-1:0] extraStates
);
  // Busy cycles of the current run, read back in the done cycle
  logic [TOTAL_W-1:0] runLen;
  always_ff @(posedge ref_clk) begin
    if (srst || !busy) runLen <= '0;
    else runLen <= runLen + TOTAL_W'(1);
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_done_pulse: assert property (done |=> !done)
    else $error("done held longer than one cycle");
  a_busy_end: assert property ($fell(busy) |-> done)
    else $error("busy fell without done");
  a_start_take: assert property (start && !busy |=>
    busy && extraStates == '0) else $error("start not taken in idle");
  a_calc_hold: assert property (busy ##1 busy |-> $stable(calcTotal))
    else $error("computed count moved during a run");
  a_final_sum: assert property (done |->
    finalTotal == calcTotal + extraStates)
    else $error("final count is not computed plus stalls");
  a_run_length: assert property (done |-> runLen ==
    (calcTotal == '0 ? TOTAL_W'(1) : calcTotal) + extraStates)
    else $error("run length differs from final count");
  a_no_stall: assert property (busy && !waitState && !bus_idle_state |=>
    $stable(extraStates)) else $error("stall counted without request");
  a_stall_step: assert property (busy |=>
    extraStates == $past(extraStates) ||
    extraStates == $past(extraStates) + TOTAL_W'(1))
    else $error("stall count jumped by more than one");
endmodule

bind instr_exec_state_timing exec_timing_sva #(.TOTAL_W(TOTAL_W)) sva_i (
  .ref_clk(ref_clk), .srst(srst), .start(start), .waitState(waitState),
  .bus_idle_state(bus_idle_state), .busy(busy), .done(done),
  .calcTotal(calcTotal), .finalTotal(finalTotal), .extraStates(extraStates)
);

/* tb/mem_wait_model.sv */
// External memory model that stretches accesses by wait and idle states
`timescale 1ns/10ps

module mem_wait_model (
  input wire logic ref_clk,
  input wire logic busy,
  input wire logic [3:0] waitCnt,
  input wire logic [3:0] idleCnt,
  output logic waitState,
  output logic bus_idle_state
);
  logic [3:0] n = 4'h0;
  initial {waitState, bus_idle_state} = 2'b00;
  // Stalls sit at the head of a run so they always fall inside it
  always @(posedge ref_clk) begin
    #1;
    // Saturate so long runs never restart the stall window
    n = !busy ? 4'h0 : (n == 4'hF) ? n : n + 4'h1;
    waitState = busy && n >= 4'h1 && n <= waitCnt;
    bus_idle_state = busy && n > waitCnt &&
      {1'b0, n} <= {1'b0, waitCnt} + {1'b0, idleCnt};
  end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the execution state sequencer
`timescale 1ns/10ps

module testbench;
  logic ref_clk = 0, srst = 1, start = 0, wordAccess = 0, oddStart = 0;
  exec_timing_pkg::bus_variant_e busVariant = exec_timing_pkg::BUS_NARROW;
  exec_timing_pkg::region_e fetchRegion = exec_timing_pkg::RG_FAST;
  exec_timing_pkg::region_e operandRegion = exec_timing_pkg::RG_FAST;
  logic [7:0] baseCount = 0, modeAdjEven = 0, modeAdjOdd = 0;
  logic [7:0] operandParam = 0, fetchParamJ = 0, fetchParamK = 0;
  logic [3:0] waitCnt = 0, idleCnt = 0;
  logic waitState, bus_idle_state, busy, done;
  logic [11:0] calcTotal, finalTotal, extraStates;
  int miscompares = 0, tests_run = 0;
  always #25 ref_clk = ~ref_clk;

  instr_exec_state_timing instr_exec_state_timing_i (.ref_clk(ref_clk),
    .srst(srst), .start(start), .busVariant(busVariant),
    .fetchRegion(fetchRegion), .operandRegion(operandRegion),
    .wordAccess(wordAccess), .oddStart(oddStart), .baseCount(baseCount),
    .modeAdjEven(modeAdjEven), .modeAdjOdd(modeAdjOdd),
    .operandParam(operandParam), .fetchParamJ(fetchParamJ),
    .fetchParamK(fetchParamK), .waitState(waitState),
    .bus_idle_state(bus_idle_state), .busy(busy), .done(done),
    .calcTotal(calcTotal), .finalTotal(finalTotal),
    .extraStates(extraStates));
  mem_wait_model mem_wait_model_i (.ref_clk(ref_clk), .busy(busy),
    .waitCnt(waitCnt), .idleCnt(idleCnt), .waitState(waitState),
    .bus_idle_state(bus_idle_state));

  task results;
    $display("Checks run %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %0d want %0d", $time, got, exp);
    end
  endtask

  // Start is held a second cycle on purpose: busy must ignore it
  task go(input logic v, input logic [1:0] f, o, input logic w, d,
    input logic [7:0] b, ae, ao, i, j, k, input logic [3:0] nw, ni,
    input logic [11:0] ec, ef);
    int n;
    busVariant = exec_timing_pkg::bus_variant_e'(v);
    fetchRegion = exec_timing_pkg::region_e'(f);
    operandRegion = exec_timing_pkg::region_e'(o);
    {wordAccess, oddStart, baseCount} = {w, d, b};
    {modeAdjEven, modeAdjOdd, operandParam} = {ae, ao, i};
    {fetchParamJ, fetchParamK, waitCnt, idleCnt} = {j, k, nw, ni};
    start = 1;
    repeat (2) @(posedge ref_clk);
    #1 start = 0;
    chk(calcTotal, ec);
    for (n = 0; n < 100 && done !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    if (n == 100) begin
      miscompares++;
      $display("ERROR %0t: no done", $time);
      results();
    end else begin
      chk(finalTotal, ef);
      chk(extraStates, ef - ec);
    end
  endtask

  task t_narrow;
    go(0,0,0,0,0,5,1,0,0,1,1,0,0,6,6);
    go(0,0,0,0,1,5,1,0,0,1,1,0,0,5,5);
    go(0,0,3,1,0,9,0,1,2,1,1,0,0,13,13);
    go(0,0,3,0,1,9,0,1,2,1,1,0,0,12,12);
    go(0,0,1,1,0,9,0,1,2,1,1,0,0,13,13);
    go(0,3,0,1,0,5,1,0,2,1,1,0,0,9,9);
    go(0,3,3,1,0,5,1,0,2,1,1,0,0,13,13);
    $display("narrow bus done");
  endtask

  task t_wide;
    go(1,0,1,1,0,5,1,0,3,1,1,0,0,7,7);
    go(1,0,1,0,0,5,1,0,3,1,1,0,0,9,9);
    go(1,0,3,1,0,9,0,1,2,1,1,0,0,13,13);
    go(1,0,3,0,0,9,0,1,2,1,1,0,0,11,11);
    go(1,0,2,1,0,5,1,0,2,1,1,0,0,8,8);
    go(1,0,2,0,1,5,1,0,2,1,1,0,0,5,5);
    go(1,1,0,0,0,5,1,0,0,1,2,0,0,7,7);
    go(1,1,1,1,0,5,1,0,2,1,2,0,0,8,8);
    go(1,1,1,0,0,5,1,0,2,1,2,0,0,9,9);
    go(1,2,0,0,0,5,3,3,0,1,1,0,0,7,7);
    go(1,3,3,1,0,5,3,3,2,1,1,0,0,13,13);
    $display("wide bus done");
  endtask

  task t_stall;
    go(0,0,0,0,0,5,1,0,0,1,1,2,1,6,6);
    go(0,3,0,1,0,5,1,0,2,1,1,2,1,9,12);
    go(1,1,0,0,0,5,1,0,0,1,2,2,1,7,10);
    go(1,2,0,0,0,5,0,0,0,1,1,3,0,7,7);
    $display("stall done");
  endtask

  task t_reset;
    start = 1;
    @(posedge ref_clk);
    #1 start = 0;
    @(posedge ref_clk);
    #1 srst = 1;
    repeat (2) @(posedge ref_clk);
    #1 srst = 0;
    chk({11'h000, busy}, 12'h000);
    chk({11'h000, done}, 12'h000);
    chk(calcTotal, 12'h000);
    chk(extraStates, 12'h000);
    chk(finalTotal, 12'h000);
    @(posedge ref_clk);
    #1;
    // A full run after the mid-run reset shows recovery
    go(0,0,0,0,0,5,1,0,0,1,1,0,0,6,6);
    $display("reset done");
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    #1 srst = 0;
    @(posedge ref_clk);
    #1;
    t_narrow();
    t_wide();
    t_stall();
    t_reset();
    results();
  end
endmodule
